// ==== bench/tmsa_host.sv ====
`timescale 1ns/1ps
// Debug host: drives the test port one bit per 400 ns tck period
module tmsa_host (
	// Clock
	input  wire logic ref_clk,
	// Test port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo_out,
	input  wire logic tdo_oe_n
);
	logic oe_bad;

	// Idle levels: tck parked low between frames, tdi at its pull-up level
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		oe_bad = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// One tck period: low five ref_clk, high three; tdo sampled just before the rise
	// so the synchronised fall has had time to update it
	task automatic bit_cyc(input logic m, input logic d, input logic sh, output logic q);
		tck = 1'b0;
		tms = m;
		tdi = d;
		repeat (5) @(negedge ref_clk);
		q = tdo_out;
		if (sh && tdo_oe_n !== 1'b0) begin
			oe_bad = 1'b1;
		end
		tck = 1'b1;
		repeat (3) @(negedge ref_clk);
	endtask

	// Clock stands still low, tdi released to its pull-up level; one edge passes
	// so that a following bit never drives the pins twice in one time step
	task automatic park();
		tck = 1'b0;
		tdi = 1'b1;
		@(negedge ref_clk);
	endtask

	// Five rises with tms high reach Test-Logic-Reset, then go to Idle
	task automatic tap_reset();
		logic q;
		repeat (5) bit_cyc(1'b1, 1'b1, 1'b0, q);
		bit_cyc(1'b0, 1'b1, 1'b0, q);
		park();
	endtask

	// LSB-first shift, access only at Update-DR entry
	task automatic scan(input logic ir, input int n, input logic [39:0] val,
		input logic pause, output logic [39:0] cap);
		logic q;
		cap = '0;
		bit_cyc(1'b1, 1'b1, 1'b0, q);
		if (ir) begin
			bit_cyc(1'b1, 1'b1, 1'b0, q);
		end
		bit_cyc(1'b0, 1'b1, 1'b0, q);
		bit_cyc(1'b0, 1'b1, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			bit_cyc(i == n - 1, val[i], 1'b1, q);
			cap[i] = q;
		end
		// Pause leaves the shifted word waiting, short of Update-DR
		bit_cyc(!pause, 1'b1, 1'b0, q);
		if (!pause) begin
			bit_cyc(1'b0, 1'b1, 1'b0, q);
		end
		park();
	endtask

	// From Pause-DR through Exit2 and Update to Idle
	task automatic resume();
		logic q;
		bit_cyc(1'b1, 1'b1, 1'b0, q);
		bit_cyc(1'b1, 1'b1, 1'b0, q);
		bit_cyc(1'b0, 1'b1, 1'b0, q);
		park();
	endtask
endmodule

// ==== bench/trace_macrocell_scan_access_tb_top.sv ====
`timescale 1ns/1ps
// Compare with case equality, count and report
`define CHK(nm, e, g) begin if ((g) !== (e)) begin \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); errors++; end n_compared++; end

module trace_macrocell_scan_access_tb_top;
	import tmsa_pkg::*;
	logic        ref_clk, reset, tck, tms, tdi, tdo_out, tdo_oe_n;
	logic        trace_mode, core_trace_sync, be, as, bc, pp;
	logic        bus_byte_enable, bus_addr_strobe, bus_burst_clock, bus_port_pin;
	logic [2:0]  core_pipe_stat;
	logic [7:0]  core_trace_pkt;
	logic [8:0]  bus_addr_hi, addr_pin_hi;
	int          errors, n_compared;
	wire  [12:0] pins  = {addr_pin_hi, be, as, bc, pp};
	wire  [12:0] bus   = {bus_addr_hi, bus_byte_enable, bus_addr_strobe, bus_burst_clock,
		bus_port_pin};
	wire  [11:0] tdata = {pins[12], pins[10:0]};

	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;

	tmsa_top dut (.ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .trace_mode(trace_mode),
		.core_trace_sync(core_trace_sync), .core_pipe_stat(core_pipe_stat),
		.core_trace_pkt(core_trace_pkt), .bus_addr_hi(bus_addr_hi),
		.bus_byte_enable(bus_byte_enable), .bus_addr_strobe(bus_addr_strobe),
		.bus_burst_clock(bus_burst_clock), .bus_port_pin(bus_port_pin),
		.addr_pin_hi(addr_pin_hi), .byte_enable_shared_pin(be),
		.address_strobe_shared_pin(as), .burst_clock_shared_pin(bc), .port_pin_shared(pp));

	tmsa_host host (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
		.tdo_oe_n(tdo_oe_n));

	////////////////////////////////////////////////////////////////////////////
	// Expected trace pins: sync, status, low nibble on address, high nibble on controls
	function automatic logic [11:0] texp(logic s, logic [2:0] st, logic [7:0] p);
		return {s, st, p[3:0], p[7], p[6], p[5], p[4]};
	endfunction

	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Chain number goes through the 4-bit select register, then INTEST
	task automatic sel_chain(input logic [3:0] c);
		logic [39:0] cap;
		host.scan(1'b1, 4, {36'h0, TMSA_IR_SCAN_N}, 1'b0, cap);
		`CHK("ir capture", TMSA_IR_CAPTURE, cap[3:0])
		host.scan(1'b0, 4, {36'h0, c}, 1'b0, cap);
		host.scan(1'b1, 4, {36'h0, TMSA_IR_INTEST}, 1'b0, cap);
	endtask

	// word is {flag, address, data}, flag one writes
	task automatic acc(input logic rw, input logic [6:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		logic [39:0] cap;
		host.scan(1'b0, 40, {rw, a, d}, 1'b0, cap);
		rd = cap[31:0];
	endtask

	// Read needs a second scan to shift the captured value out; junk data both times
	task automatic rd_chk(input logic [6:0] a, input logic [31:0] e);
		logic [31:0] rd;
		acc(1'b0, a, $urandom, rd);
		acc(1'b0, a, $urandom, rd);
		`CHK("read data", e, rd)
	endtask

	// Hang guard
	initial begin
		repeat (80000) @(posedge ref_clk);
		$display("[FAIL] watchdog expected done seen running");
		errors++;
		finish_test();
	end

	initial begin
		logic [31:0] mem [128];
		logic [6:0]  al [6];
		logic [31:0] d, rdv;
		logic [39:0] cap;
		int          w;
		errors = 0;
		n_compared = 0;
		reset = 1'b1;
		trace_mode = 1'b0;
		{core_trace_sync, core_pipe_stat, core_trace_pkt} = 12'h000;
		{bus_addr_hi, bus_byte_enable, bus_addr_strobe, bus_burst_clock, bus_port_pin} = 13'h0;
		void'($urandom(94));
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		`CHK("reset pins", 13'h0, pins)
		`CHK("reset tdo enable", 1'b1, tdo_oe_n)
		repeat (4) @(negedge ref_clk);
		host.tap_reset();
		sel_chain(TMSA_CHAIN_TRACE);
		rd_chk(TMSA_REG_CTRL, TMSA_CTRL_RST);
		// Both ends of plain storage, then random places
		for (int k = 0; k < 6; k++) begin
			al[k] = (k == 0) ? 7'h02 : (k == 1) ? 7'h7F : 7'(2 + $urandom % 126);
			d = $urandom;
			mem[al[k]] = d;
			acc(1'b1, al[k], d, rdv);
		end
		for (int k = 0; k < 6; k++) begin
			rd_chk(al[k], mem[al[k]]);
		end
		// A write through another chain must not land
		sel_chain(4'h5);
		acc(1'b1, 7'h02, ~mem[2], rdv);
		sel_chain(TMSA_CHAIN_TRACE);
		rd_chk(7'h02, mem[2]);
		// Status follows the mode input and ignores writes
		trace_mode = 1'b1;
		acc(1'b1, TMSA_REG_STAT, 32'h0000_0000, rdv);
		rd_chk(TMSA_REG_STAT, 32'h0000_0001);
		trace_mode = 1'b0;
		rd_chk(TMSA_REG_STAT, 32'h0000_0000);
		// Normal bus functions one cycle later
		for (int k = 0; k < 6; k++) begin
			{bus_addr_hi, bus_byte_enable, bus_addr_strobe, bus_burst_clock,
				bus_port_pin} = 13'($urandom);
			@(negedge ref_clk);
			`CHK("bus pins", bus, pins)
		end
		// Enable write parked in Pause-DR must not act yet
		trace_mode = 1'b1;
		{core_trace_sync, core_pipe_stat, core_trace_pkt} = 12'hFFF;
		host.scan(1'b0, 40, {1'b1, TMSA_REG_CTRL, 32'h0000_0001}, 1'b1, cap);
		repeat (8) @(negedge ref_clk);
		`CHK("trace gated", 12'h000, tdata)
		host.resume();
		repeat (4) @(negedge ref_clk);
		// Trace data loads as the trace clock falls
		for (int k = 0; k < 8; k++) begin
			{core_trace_sync, core_pipe_stat, core_trace_pkt} = (k == 0) ? 12'hFFF :
				12'($urandom);
			repeat (4) @(negedge ref_clk);
			w = 0;
			while (pins[11] !== 1'b1 && w < 4) begin
				@(negedge ref_clk);
				w++;
			end
			if (pins[11] !== 1'b1) begin
				$display("[FAIL] trace clock rise expected 1 seen %b", pins[11]);
				errors++;
				finish_test();
			end
			@(negedge ref_clk);
			`CHK("trace clock low", 1'b0, pins[11])
			`CHK("trace data", texp(core_trace_sync, core_pipe_stat, core_trace_pkt), tdata)
			@(negedge ref_clk);
			`CHK("trace clock high", 1'b1, pins[11])
		end
		`CHK("shift tdo enable", 1'b0, host.oe_bad)
		finish_test();
	end
endmodule

// ==== design/tmsa_acc_if.sv ====
`timescale 1ns/1ps
// Register access request from the scan chain to the macrocell registers
interface tmsa_acc_if;
	import tmsa_pkg::*;
	logic                   req;
	logic                   wr;
	logic [TMSA_ADDR_W-1:0] addr;
	logic [TMSA_DATA_W-1:0] wdata;
	logic [TMSA_DATA_W-1:0] rdata;
	logic                   trace_en;

	modport master (output req, output wr, output addr, output wdata,
		input rdata, input trace_en);
	modport slave (input req, input wr, input addr, input wdata,
		output rdata, output trace_en);
endinterface

// ==== design/tmsa_pkg.sv ====
package tmsa_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Test access port instruction codes and chain selection
	localparam int         TMSA_IR_W          = 4;
	localparam logic [3:0] TMSA_IR_SCAN_N     = 4'h2;
	localparam logic [3:0] TMSA_IR_INTEST     = 4'hC;
	localparam logic [3:0] TMSA_IR_BYPASS     = 4'hF;
	localparam logic [3:0] TMSA_IR_CAPTURE    = 4'h1;
	localparam int         TMSA_CHAIN_SEL_W   = 4;
	localparam logic [3:0] TMSA_CHAIN_TRACE   = 4'h6;
	localparam logic [3:0] TMSA_CHAIN_RST     = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Trace chain layout: data, address, read/write flag
	localparam int TMSA_CHAIN_W  = 40;
	localparam int TMSA_DATA_W   = 32;
	localparam int TMSA_ADDR_W   = 7;
	localparam int TMSA_DATA_LSB = 0;
	localparam int TMSA_ADDR_LSB = 32;
	localparam int TMSA_RW_BIT   = 39;

	////////////////////////////////////////////////////////////////////////////
	// Macrocell register numbers and reset values
	localparam logic [6:0]  TMSA_REG_CTRL    = 7'h00;
	localparam logic [6:0]  TMSA_REG_STAT    = 7'h01;
	localparam int          TMSA_CTRL_EN_BIT = 0;
	localparam logic [31:0] TMSA_CTRL_RST    = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Test access port controller states, one-hot
	typedef enum logic [15:0] {
		TMSA_TAP_RESET    = 16'h0001,
		TMSA_TAP_IDLE     = 16'h0002,
		TMSA_TAP_SEL_DR   = 16'h0004,
		TMSA_TAP_CAP_DR   = 16'h0008,
		TMSA_TAP_SHIFT_DR = 16'h0010,
		TMSA_TAP_EXIT1_DR = 16'h0020,
		TMSA_TAP_PAUSE_DR = 16'h0040,
		TMSA_TAP_EXIT2_DR = 16'h0080,
		TMSA_TAP_UPD_DR   = 16'h0100,
		TMSA_TAP_SEL_IR   = 16'h0200,
		TMSA_TAP_CAP_IR   = 16'h0400,
		TMSA_TAP_SHIFT_IR = 16'h0800,
		TMSA_TAP_EXIT1_IR = 16'h1000,
		TMSA_TAP_PAUSE_IR = 16'h2000,
		TMSA_TAP_EXIT2_IR = 16'h4000,
		TMSA_TAP_UPD_IR   = 16'h8000
	} tmsa_tap_t;

endpackage

// ==== design/tmsa_regs.sv ====
`timescale 1ns/1ps
module tmsa_regs #(
	parameter int DEPTH = 128
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset,
	// State shown in the status register
	input  wire logic trace_mode,
	// Access from the scan chain
	tmsa_acc_if.slave acc
);
	import tmsa_pkg::*;

	logic [TMSA_DATA_W-1:0] mem [0:DEPTH-1];
	logic [TMSA_DATA_W-1:0] ctrl_q;
	logic [TMSA_DATA_W-1:0] rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Control register, held apart so that it has a reset value
	// write of control
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_q <= TMSA_CTRL_RST;
		end else if (acc.req && acc.wr && acc.addr == TMSA_REG_CTRL) begin
			ctrl_q <= acc.wdata;
		end
	end

	// General registers; no reset, software sets them before use
	// write of general registers
	always_ff @(posedge ref_clk) begin
		if (acc.req && acc.wr) begin
			mem[acc.addr] <= acc.wdata;
		end
	end

	// Read data held until the next read, so a late capture still sees it
	// read ignores data field
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (acc.req && !acc.wr) begin
			if (acc.addr == TMSA_REG_CTRL) begin
				rdata_q <= ctrl_q;
			end else if (acc.addr == TMSA_REG_STAT) begin
				rdata_q <= {31'h0000_0000, trace_mode};
			end else begin
				rdata_q <= mem[acc.addr];
			end
		end
	end

	assign acc.rdata    = rdata_q;
	assign acc.trace_en = ctrl_q[TMSA_CTRL_EN_BIT];

	////////////////////////////////////////////////////////////////////////////
	chk_ctrl_write: assert property (@(posedge ref_clk) disable iff (reset)
		acc.req && acc.wr && acc.addr == TMSA_REG_CTRL
		|=> acc.trace_en == $past(acc.wdata[TMSA_CTRL_EN_BIT]))
		else $error("control write not taken");
	chk_read_no_write: assert property (@(posedge ref_clk) disable iff (reset)
		acc.req && !acc.wr |=> $stable(ctrl_q))
		else $error("read request changed control register");
	chk_stat_read: assert property (@(posedge ref_clk) disable iff (reset)
		acc.req && !acc.wr && acc.addr == TMSA_REG_STAT
		|=> acc.rdata == {31'h0000_0000, $past(trace_mode)})
		else $error("status read returned wrong value");
endmodule

// ==== design/tmsa_top.sv ====
`timescale 1ns/1ps
// Function
// - Registers reached only through test port, scan chain number six
// - Chain is 40 bits: 32 data, 7 address, one read/write flag
// - Host reads with flag zero; data field is ignored
// - Access happens on entering Update-DR, never while shifting
// - Trace mode with control bit 0 set puts sync on address bit 24 pin
// - Trace mode puts trace clock on address bit 23 pin
// - Trace mode with control bit 0 set puts 3-bit pipeline status on address bits 22..20
// - Trace mode with control bit 0 set puts 8-bit packet on shared control pins, address 19..16
module tmsa_top (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// Test access port pins
	input  wire logic       tck,
	input  wire logic       tms,
	input  wire logic       tdi,
	output logic            tdo_out,
	output logic            tdo_oe_n,
	// Trace source and mode select
	input  wire logic       trace_mode,
	input  wire logic       core_trace_sync,
	input  wire logic [2:0] core_pipe_stat,
	input  wire logic [7:0] core_trace_pkt,
	// Normal bus functions of the shared pins
	input  wire logic [8:0] bus_addr_hi,
	input  wire logic       bus_byte_enable,
	input  wire logic       bus_addr_strobe,
	input  wire logic       bus_burst_clock,
	input  wire logic       bus_port_pin,
	// Shared pins
	output logic [8:0]      addr_pin_hi,
	output logic            byte_enable_shared_pin,
	output logic            address_strobe_shared_pin,
	output logic            burst_clock_shared_pin,
	output logic            port_pin_shared
);
	import tmsa_pkg::*;

	tmsa_acc_if acc ();

	logic [1:0]               tck_s_q, tms_s_q, tdi_s_q;
	logic                     tck_prev_q;
	logic                     tck_rise, tck_fall;
	tmsa_tap_t                tap_q, tap_d;
	logic [TMSA_IR_W-1:0]     ir_q, ir_sr_q;
	logic [3:0]               chain_q, chain_sr_q;
	logic [TMSA_CHAIN_W-1:0]  trace_sr_q;
	logic                     byp_q;
	logic                     sel_trace;
	logic                     req_q;

	////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers; tck edges are found only after the second stage
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tck_s_q    <= 2'h0;
			tms_s_q    <= 2'h3;
			tdi_s_q    <= 2'h0;
			tck_prev_q <= 1'b0;
		end else begin
			tck_s_q    <= {tck_s_q[0], tck};
			tms_s_q    <= {tms_s_q[0], tms};
			tdi_s_q    <= {tdi_s_q[0], tdi};
			tck_prev_q <= tck_s_q[1];
		end
	end

	assign tck_rise = tck_s_q[1] && !tck_prev_q;
	assign tck_fall = !tck_s_q[1] && tck_prev_q;

	assign sel_trace = ir_q == TMSA_IR_INTEST && chain_q == TMSA_CHAIN_TRACE;

	////////////////////////////////////////////////////////////////////////////
	// Controller next state from the sampled mode select
	function automatic tmsa_tap_t tap_next(tmsa_tap_t s, logic m);
		tmsa_tap_t n;
		n = TMSA_TAP_RESET;
		case (s)
			TMSA_TAP_RESET:    n = m ? TMSA_TAP_RESET    : TMSA_TAP_IDLE;
			TMSA_TAP_IDLE:     n = m ? TMSA_TAP_SEL_DR   : TMSA_TAP_IDLE;
			TMSA_TAP_SEL_DR:   n = m ? TMSA_TAP_SEL_IR   : TMSA_TAP_CAP_DR;
			TMSA_TAP_CAP_DR:   n = m ? TMSA_TAP_EXIT1_DR : TMSA_TAP_SHIFT_DR;
			TMSA_TAP_SHIFT_DR: n = m ? TMSA_TAP_EXIT1_DR : TMSA_TAP_SHIFT_DR;
			TMSA_TAP_EXIT1_DR: n = m ? TMSA_TAP_UPD_DR   : TMSA_TAP_PAUSE_DR;
			TMSA_TAP_PAUSE_DR: n = m ? TMSA_TAP_EXIT2_DR : TMSA_TAP_PAUSE_DR;
			TMSA_TAP_EXIT2_DR: n = m ? TMSA_TAP_UPD_DR   : TMSA_TAP_SHIFT_DR;
			TMSA_TAP_UPD_DR:   n = m ? TMSA_TAP_SEL_DR   : TMSA_TAP_IDLE;
			TMSA_TAP_SEL_IR:   n = m ? TMSA_TAP_RESET    : TMSA_TAP_CAP_IR;
			TMSA_TAP_CAP_IR:   n = m ? TMSA_TAP_EXIT1_IR : TMSA_TAP_SHIFT_IR;
			TMSA_TAP_SHIFT_IR: n = m ? TMSA_TAP_EXIT1_IR : TMSA_TAP_SHIFT_IR;
			TMSA_TAP_EXIT1_IR: n = m ? TMSA_TAP_UPD_IR   : TMSA_TAP_PAUSE_IR;
			TMSA_TAP_PAUSE_IR: n = m ? TMSA_TAP_EXIT2_IR : TMSA_TAP_PAUSE_IR;
			TMSA_TAP_EXIT2_IR: n = m ? TMSA_TAP_UPD_IR   : TMSA_TAP_SHIFT_IR;
			TMSA_TAP_UPD_IR:   n = m ? TMSA_TAP_SEL_DR   : TMSA_TAP_IDLE;
			default:           n = TMSA_TAP_RESET;
		endcase
		return n;
	endfunction

	assign tap_d = tap_next(tap_q, tms_s_q[1]);

	// Controller state advances once per test clock rising edge
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tap_q <= TMSA_TAP_RESET;
		end else if (tck_rise) begin
			tap_q <= tap_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Instruction register and chain number register
	always_ff @(posedge ref_clk) begin
		if (reset || tap_q == TMSA_TAP_RESET) begin
			ir_q       <= TMSA_IR_BYPASS;
			ir_sr_q    <= TMSA_IR_CAPTURE;
			chain_q    <= TMSA_CHAIN_RST;
			chain_sr_q <= TMSA_CHAIN_RST;
		end else if (tck_rise) begin
			case (tap_q)
				TMSA_TAP_CAP_IR:   ir_sr_q <= TMSA_IR_CAPTURE;
				TMSA_TAP_SHIFT_IR: ir_sr_q <= {tdi_s_q[1], ir_sr_q[TMSA_IR_W-1:1]};
				TMSA_TAP_UPD_IR:   ir_q    <= ir_sr_q;
				TMSA_TAP_CAP_DR:   chain_sr_q <= chain_q;
				TMSA_TAP_SHIFT_DR: begin
					if (ir_q == TMSA_IR_SCAN_N) begin
						chain_sr_q <= {tdi_s_q[1], chain_sr_q[3:1]};
					end
				end
				TMSA_TAP_UPD_DR: begin
					if (ir_q == TMSA_IR_SCAN_N) begin
						chain_q <= chain_sr_q;
					end
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trace chain and bypass bit; shifts least significant bit first
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			trace_sr_q <= '0;
			byp_q      <= 1'b0;
		end else if (tck_rise) begin
			if (tap_q == TMSA_TAP_CAP_DR) begin
				byp_q <= 1'b0;
				if (sel_trace) begin
					trace_sr_q[TMSA_DATA_LSB +: TMSA_DATA_W] <= acc.rdata;
				end
			end else if (tap_q == TMSA_TAP_SHIFT_DR) begin
				byp_q <= tdi_s_q[1];
				if (sel_trace) begin
					trace_sr_q <= {tdi_s_q[1], trace_sr_q[TMSA_CHAIN_W-1:1]};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register access request, a single-cycle pulse
	// access on entering Update-DR
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			req_q <= 1'b0;
		end else begin
			req_q <= tck_rise && tap_d == TMSA_TAP_UPD_DR && sel_trace;
		end
	end

	// Fields are stable in Update-DR since shifting has stopped
	// write flag and fields
	assign acc.req   = req_q;
	assign acc.wr    = trace_sr_q[TMSA_RW_BIT];
	assign acc.addr  = trace_sr_q[TMSA_ADDR_LSB +: TMSA_ADDR_W];
	assign acc.wdata = trace_sr_q[TMSA_DATA_LSB +: TMSA_DATA_W];

	tmsa_regs #(
		.DEPTH (128)
	) u_regs (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.trace_mode (trace_mode),
		.acc        (acc)
	);

	////////////////////////////////////////////////////////////////////////////
	// Data out changes on the falling test clock, driven only while shifting
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tdo_out  <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			tdo_oe_n <= !(tap_q == TMSA_TAP_SHIFT_DR || tap_q == TMSA_TAP_SHIFT_IR);
			if (tap_q == TMSA_TAP_SHIFT_IR) begin
				tdo_out <= ir_sr_q[0];
			end else if (ir_q == TMSA_IR_SCAN_N) begin
				tdo_out <= chain_sr_q[0];
			end else if (sel_trace) begin
				tdo_out <= trace_sr_q[0];
			end else begin
				tdo_out <= byp_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared pin mux. Trace clock is ref_clk/2; data moves on its falling
	// side so the capture probe sees it stable a full cycle either side.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			addr_pin_hi               <= 9'h000;
			byte_enable_shared_pin    <= 1'b0;
			address_strobe_shared_pin <= 1'b0;
			burst_clock_shared_pin    <= 1'b0;
			port_pin_shared           <= 1'b0;
		end else if (trace_mode) begin
			addr_pin_hi[7] <= !addr_pin_hi[7];
			if (addr_pin_hi[7]) begin
				addr_pin_hi[8]            <= core_trace_sync && acc.trace_en;
				addr_pin_hi[6:4]          <= core_pipe_stat & {3{acc.trace_en}};
				addr_pin_hi[3:0]          <= core_trace_pkt[3:0] & {4{acc.trace_en}};
				byte_enable_shared_pin    <= core_trace_pkt[7] && acc.trace_en;
				address_strobe_shared_pin <= core_trace_pkt[6] && acc.trace_en;
				burst_clock_shared_pin    <= core_trace_pkt[5] && acc.trace_en;
				port_pin_shared           <= core_trace_pkt[4] && acc.trace_en;
			end
		end else begin
			addr_pin_hi               <= bus_addr_hi;
			byte_enable_shared_pin    <= bus_byte_enable;
			address_strobe_shared_pin <= bus_addr_strobe;
			burst_clock_shared_pin    <= bus_burst_clock;
			port_pin_shared           <= bus_port_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	chk_chain_select: assert property (@(posedge ref_clk) disable iff (reset)
		acc.req |-> chain_q == TMSA_CHAIN_TRACE && ir_q == TMSA_IR_INTEST)
		else $error("access without chain six selected");
	chk_update_only: assert property (@(posedge ref_clk) disable iff (reset)
		acc.req |-> tap_q == TMSA_TAP_UPD_DR && $past(tap_q) != TMSA_TAP_UPD_DR)
		else $error("access outside entry to Update-DR");
	chk_no_shift_req: assert property (@(posedge ref_clk) disable iff (reset)
		tap_q == TMSA_TAP_SHIFT_DR |-> !acc.req)
		else $error("access during shifting");
	chk_shift_in: assert property (@(posedge ref_clk) disable iff (reset)
		tck_rise && tap_q == TMSA_TAP_SHIFT_DR && sel_trace
		|=> trace_sr_q[TMSA_CHAIN_W-1] == $past(tdi_s_q[1])
		&& trace_sr_q[TMSA_CHAIN_W-2:0] == $past(trace_sr_q[TMSA_CHAIN_W-1:1]))
		else $error("trace chain shift wrong");
	chk_capture_read: assert property (@(posedge ref_clk) disable iff (reset)
		tck_rise && tap_q == TMSA_TAP_CAP_DR && sel_trace
		|=> trace_sr_q[31:0] == $past(acc.rdata))
		else $error("read value not captured");
	chk_trace_clock: assert property (@(posedge ref_clk) disable iff (reset)
		trace_mode ##1 trace_mode |-> addr_pin_hi[7] != $past(addr_pin_hi[7]))
		else $error("trace clock not toggling");
	chk_sync_pin: assert property (@(posedge ref_clk) disable iff (reset)
		trace_mode && addr_pin_hi[7]
		|=> addr_pin_hi[8] == $past(core_trace_sync && acc.trace_en))
		else $error("sync pin wrong");
	chk_status_pins: assert property (@(posedge ref_clk) disable iff (reset)
		trace_mode && addr_pin_hi[7]
		|=> addr_pin_hi[6:4] == $past(core_pipe_stat & {3{acc.trace_en}}))
		else $error("pipeline status pins wrong");
	chk_packet_pins: assert property (@(posedge ref_clk) disable iff (reset)
		trace_mode && addr_pin_hi[7] |=> {byte_enable_shared_pin,
		address_strobe_shared_pin, burst_clock_shared_pin, port_pin_shared,
		addr_pin_hi[3:0]} == $past(core_trace_pkt & {8{acc.trace_en}}))
		else $error("packet pins wrong");
	chk_bus_revert: assert property (@(posedge ref_clk) disable iff (reset)
		!trace_mode |=> addr_pin_hi == $past(bus_addr_hi)
		&& byte_enable_shared_pin == $past(bus_byte_enable))
		else $error("shared pins not on bus function");
endmodule
